//--- rtl/adc_defs.svh
`ifndef ADC_DEFS_SVH
`define ADC_DEFS_SVH

// register byte offsets on the AXI4-Lite port
`define OFS_SC1 8'h00
`define OFS_SC2 8'h04
`define OFS_RESULT_HIGH 8'h08
`define OFS_RESULT_LOW 8'h0C
`define OFS_CV_HIGH 8'h10
`define OFS_CV_LOW 8'h14
`define OFS_CFG 8'h18
`define OFS_PIN_FIRST 8'h1C
`define OFS_PIN_SECOND 8'h20

// reset values
`define SC1_RESET 8'h1F
`define SC2_RESET 8'h00
`define CFG_RESET 8'h00
`define PIN_RESET 8'h00

// field codes and positions
`define CHANNEL_OFF 5'h1F
`define SRC_BUS 2'h0
`define SRC_BUS_HALF 2'h1
`define SRC_ALT 2'h2
`define SRC_ASYNC 2'h3
`define RES_8BIT 2'h0
`define RES_12BIT 2'h1
`define RES_10BIT 2'h2
`define SC2_ZERO_MASK 8'h0F

// sample phase in half conversion-clock cycles
`define SAMPLE_SHORT_HALF 7
`define SAMPLE_LONG_HALF 47
// bus cycles per tick of the internal asynchronous conversion clock
`define ASYNC_CLOCK_DIV 4

// AXI response codes
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- rtl/adc_pkg.sv
package adc_pkg;

	typedef enum logic [1:0] {
		st_idle,
		st_sample,
		st_convert
	} conv_state_type;

	typedef struct packed {
		logic low_power_select;
		logic [1:0] clock_divider;
		logic long_sample_select;
		logic [1:0] resolution;
		logic [1:0] input_clock_source;
	} converter_configuration_type;

	typedef struct packed {
		logic completion_flag;
		logic completion_interrupt_enable;
		logic continuous_select;
		logic [4:0] channel_select;
	} status_control_one_type;

	typedef struct packed {
		logic trigger_select;
		logic compare_enable;
		logic compare_greater_select;
	} status_control_two_type;

	typedef struct packed {
		logic sampling;
		logic converting;
		logic [4:0] channel_select;
	} frontend_type;

endpackage

//--- rtl/adc_lowpower_mode_control.sv
// The address map and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "adc_defs.svh"

// Overview of operation
// - conversion running at wait entry completes, never aborted
// - in wait, hardware trigger or continuous mode still starts conversions
// - bus, bus halved and async clock all stay usable in wait
// - completion in wait sets completion flag; interrupt when enabled
// - stop without async clock aborts conversion and returns to idle
// - stop3 entry or exit leaves result bytes unchanged
// - after stop3 abort, stay idle until software or hardware trigger
// - with async clock selected, converter keeps running through stop3
// - async clock in stop3: running conversion completes, triggers still start
// - completion in stop3 sets flag and raises wake interrupt when enabled
// - stop2 disables converter; all registers hold reset values afterwards
// - configuration: low power, divider, long sample, resolution, clock source
// - control two: active flag, trigger select, compare enable, greater select
// - control two bits 3:2 read zero; bits 1:0 written zero
// - control one: completion flag, interrupt enable, continuous, channel select
// - channel code 00001 routes analog input 1 to converter
// - compare value pair holds value used when compare enabled
// - pin control bits disable digital I/O on matching analog pins
// - control one write aborts; with software trigger starts new conversion unless channel all ones
// - in 10/12-bit mode, high read without low read blocks new result and flag
// - sample phase 3.5 clock cycles short, 23.5 cycles long; sampling here lasts 4 and 24 conversion-clock ticks
module adc_lowpower_mode_control #(
	parameter int ASYNC_DIV = `ASYNC_CLOCK_DIV
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic wait_mode,
	input wire logic stop3_mode,
	input wire logic stop2_mode,
	input wire logic hardware_trigger_input,
	input wire logic alternate_clock_input,
	input wire logic [11:0] conversion_data,
	output var adc_pkg::frontend_type frontend,
	output logic [15:0] analog_pin_disable,
	output logic converter_irq
);
	import adc_pkg::*;

	localparam logic [5:0] SAMPLE_SHORT = 6'((`SAMPLE_SHORT_HALF + 1) / 2 - 1);
	localparam logic [5:0] SAMPLE_LONG = 6'((`SAMPLE_LONG_HALF + 1) / 2 - 1);
	localparam logic [7:0] ASYNC_LIMIT = 8'(ASYNC_DIV - 1);

	logic mod_rst;
	logic aw_held_r, w_held_r, awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
	logic [7:0] awaddr_r;
	logic [7:0] wdata_r;
	logic wstrb0_r;
	logic [1:0] bresp_r, rresp_r;
	logic [31:0] rdata_r;
	logic wr_fire, wr_en, rd_fire, wr_mapped, rd_mapped;
	logic [7:0] rd_word;
	converter_configuration_type cfg_r;
	status_control_one_type sc1_r;
	status_control_two_type sc2_r;
	logic [11:0] cv_r, result_r, hold_r;
	logic [7:0] pin_first_r, pin_second_r;
	logic block_r, active_r, irq_r;
	frontend_type frontend_r;
	conv_state_type state_r, state_nxt;
	logic [5:0] cnt_r, cnt_nxt, sample_len, conv_len;
	logic [7:0] pre_cnt_r, base_limit;
	logic [2:0] div_cnt_r, div_mask;
	logic base_tick, adck_tick;
	logic [2:0] sync_r [2];
	logic [1:0] level_r, edge_in;
	logic sc1_wr, mode_wr, stop_abort, abort, start, complete, complete_ok;
	logic [12:0] cmp_diff;
	logic cond_met, transfer, restart;
	logic [11:0] conv_value;

	// stop2 forces every register outside the AXI channel logic to its reset value
	assign mod_rst = !aresetn || stop2_mode;

	// AXI4-Lite write channel: address and data taken in either order
	assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
	assign wr_en = wr_fire && wstrb0_r && wr_mapped;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			awready_r <= 1'b1;
			awaddr_r <= '0;
		end else if (s_axi_awvalid && awready_r) begin
			aw_held_r <= 1'b1;
			awready_r <= 1'b0;
			awaddr_r <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_held_r <= 1'b0;
			awready_r <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_r <= 1'b0;
			wready_r <= 1'b1;
			wdata_r <= '0;
			wstrb0_r <= 1'b0;
		end else if (s_axi_wvalid && wready_r) begin
			w_held_r <= 1'b1;
			wready_r <= 1'b0;
			wdata_r <= s_axi_wdata[7:0];
			wstrb0_r <= s_axi_wstrb[0];
		end else if (wr_fire) begin
			w_held_r <= 1'b0;
			wready_r <= 1'b1;
		end
	end

	always_comb begin
		case (awaddr_r)
			`OFS_SC1, `OFS_SC2, `OFS_RESULT_HIGH, `OFS_RESULT_LOW, `OFS_CV_HIGH,
			`OFS_CV_LOW, `OFS_CFG, `OFS_PIN_FIRST, `OFS_PIN_SECOND: wr_mapped = 1'b1;
			default: wr_mapped = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r <= `RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_r <= 1'b1;
			bresp_r <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// AXI4-Lite read channel
	assign rd_fire = s_axi_arvalid && arready_r;

	always_comb begin
		rd_mapped = 1'b1;
		case (s_axi_araddr)
			`OFS_SC1: rd_word = sc1_r;
			`OFS_SC2: rd_word = {active_r, sc2_r, 4'h0};
			`OFS_RESULT_HIGH: rd_word = {4'h0, result_r[11:8]};
			`OFS_RESULT_LOW: rd_word = result_r[7:0];
			`OFS_CV_HIGH: rd_word = {4'h0, cv_r[11:8]};
			`OFS_CV_LOW: rd_word = cv_r[7:0];
			`OFS_CFG: rd_word = cfg_r;
			`OFS_PIN_FIRST: rd_word = pin_first_r;
			`OFS_PIN_SECOND: rd_word = pin_second_r;
			default: begin
				rd_word = 8'h00;
				rd_mapped = 1'b0;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= `RESP_OKAY;
		end else if (rd_fire) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b1;
			rdata_r <= {24'h000000, rd_word};
			rresp_r <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_rready && rvalid_r) begin
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
		end
	end

	// pin inputs: three flops, a change counts once the last two agree
	for (genvar i = 0; i < 2; i++) begin : g_sync
		always_ff @(posedge aclk) begin
			if (mod_rst) begin
				sync_r[i] <= 3'h0;
				level_r[i] <= 1'b0;
			end else begin
				sync_r[i] <= {sync_r[i][1:0], i == 0 ? hardware_trigger_input :
					alternate_clock_input};
				if (sync_r[i][1] == sync_r[i][2]) begin
					level_r[i] <= sync_r[i][2];
				end
			end
		end
		assign edge_in[i] = (sync_r[i][1] == sync_r[i][2]) && sync_r[i][2] && !level_r[i];
	end

	// conversion clock: source tick, then power-of-two divider
	always_comb begin
		case (cfg_r.input_clock_source)
			`SRC_BUS: base_limit = 8'h00;
			`SRC_BUS_HALF: base_limit = 8'h01;
			default: base_limit = ASYNC_LIMIT;
		endcase
		base_tick = (cfg_r.input_clock_source == `SRC_ALT) ? edge_in[1] :
			(pre_cnt_r >= base_limit);
		case (cfg_r.clock_divider)
			2'h0: div_mask = 3'h0;
			2'h1: div_mask = 3'h1;
			2'h2: div_mask = 3'h3;
			default: div_mask = 3'h7;
		endcase
		adck_tick = base_tick && ((div_cnt_r & div_mask) == div_mask);
	end

	always_ff @(posedge aclk) begin
		if (mod_rst) begin
			pre_cnt_r <= 8'h00;
			div_cnt_r <= 3'h0;
		end else begin
			pre_cnt_r <= base_tick ? 8'h00 : pre_cnt_r + 8'h01;
			if (base_tick) begin
				div_cnt_r <= div_cnt_r + 3'h1;
			end
		end
	end

	// conversion sequencing
	assign sc1_wr = wr_en && awaddr_r == `OFS_SC1;
	assign mode_wr = wr_en && (awaddr_r == `OFS_SC2 || awaddr_r == `OFS_CFG ||
		awaddr_r == `OFS_CV_HIGH || awaddr_r == `OFS_CV_LOW);
	assign stop_abort = stop3_mode && cfg_r.input_clock_source != `SRC_ASYNC;
	assign abort = sc1_wr || mode_wr || stop_abort;
	// after a stop abort only a new trigger restarts the converter
	// trigger edge only starts an idle converter, never cuts a conversion short
	assign start = !stop_abort && ((sc1_wr && wdata_r[4:0] != `CHANNEL_OFF &&
		!sc2_r.trigger_select) || (!abort && state_r == st_idle && edge_in[0] &&
		sc2_r.trigger_select && sc1_r.channel_select != `CHANNEL_OFF));
	assign sample_len = cfg_r.long_sample_select ? SAMPLE_LONG : SAMPLE_SHORT;

	always_comb begin
		case (cfg_r.resolution)
			`RES_12BIT: begin
				conv_len = 6'h0B;
				conv_value = hold_r;
			end
			`RES_10BIT: begin
				conv_len = 6'h09;
				conv_value = {2'h0, hold_r[11:2]};
			end
			default: begin
				conv_len = 6'h07;
				conv_value = {4'h0, hold_r[11:4]};
			end
		endcase
	end

	assign cmp_diff = {1'b0, conv_value} - {1'b0, cv_r};
	assign cond_met = !sc2_r.compare_enable ||
		(sc2_r.compare_greater_select ? !cmp_diff[12] : cmp_diff[12]);
	assign complete_ok = complete && !abort;
	assign transfer = complete_ok && cond_met && !block_r;
	// a blocked result retriggers unless a single compare failed
	assign restart = sc1_r.continuous_select || (block_r && cond_met);

	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		complete = 1'b0;
		case (state_r)
			st_idle: begin
			end
			st_sample: begin
				if (adck_tick) begin
					if (cnt_r == 6'h00) begin
						state_nxt = st_convert;
						cnt_nxt = conv_len;
					end else begin
						cnt_nxt = cnt_r - 6'h01;
					end
				end
			end
			st_convert: begin
				if (adck_tick) begin
					if (cnt_r == 6'h00) begin
						complete = 1'b1;
						state_nxt = st_idle;
					end else begin
						cnt_nxt = cnt_r - 6'h01;
					end
				end
			end
			default: state_nxt = st_idle;
		endcase
		if (abort) begin
			state_nxt = st_idle;
		end
		if (start || (complete_ok && restart && !stop_abort)) begin
			state_nxt = st_sample;
			cnt_nxt = sample_len;
		end
	end

	always_ff @(posedge aclk) begin
		if (mod_rst) begin
			state_r <= st_idle;
			cnt_r <= 6'h00;
			active_r <= 1'b0;
			hold_r <= 12'h000;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			active_r <= state_nxt != st_idle;
			if (state_r == st_sample && state_nxt == st_convert) begin
				hold_r <= conversion_data;
			end
		end
	end

	// result pair changes only on a successful transfer
	always_ff @(posedge aclk) begin
		if (mod_rst) begin
			result_r <= 12'h000;
		end else if (transfer) begin
			result_r <= sc2_r.compare_enable ? cmp_diff[11:0] : conv_value;
		end
	end

	// in 10- or 12-bit mode a high read guards the pair until the low byte is read
	always_ff @(posedge aclk) begin
		if (mod_rst) begin
			block_r <= 1'b0;
		end else if (rd_fire && s_axi_araddr == `OFS_RESULT_HIGH &&
			cfg_r.resolution != `RES_8BIT) begin
			block_r <= 1'b1;
		end else if (rd_fire && s_axi_araddr == `OFS_RESULT_LOW) begin
			block_r <= 1'b0;
		end
	end

	// software registers
	always_ff @(posedge aclk) begin
		if (mod_rst) begin
			sc1_r <= `SC1_RESET;
			sc2_r <= status_control_two_type'(`SC2_RESET >> 4);
			cfg_r <= `CFG_RESET;
			cv_r <= 12'h000;
			pin_first_r <= `PIN_RESET;
			pin_second_r <= `PIN_RESET;
		end else begin
			// set wins over clear
			if (transfer) begin
				sc1_r.completion_flag <= 1'b1;
			end else if (sc1_wr || (rd_fire && s_axi_araddr == `OFS_RESULT_LOW)) begin
				sc1_r.completion_flag <= 1'b0;
			end
			if (sc1_wr) begin
				sc1_r.completion_interrupt_enable <= wdata_r[6];
				sc1_r.continuous_select <= wdata_r[5];
				sc1_r.channel_select <= wdata_r[4:0];
			end
			if (wr_en && awaddr_r == `OFS_SC2) begin
				sc2_r <= wdata_r[6:4];
			end
			if (wr_en && awaddr_r == `OFS_CFG) begin
				cfg_r <= converter_configuration_type'(wdata_r);
			end
			if (wr_en && awaddr_r == `OFS_CV_HIGH) begin
				cv_r[11:8] <= wdata_r[3:0];
			end
			if (wr_en && awaddr_r == `OFS_CV_LOW) begin
				cv_r[7:0] <= wdata_r;
			end
			if (wr_en && awaddr_r == `OFS_PIN_FIRST) begin
				pin_first_r <= wdata_r;
			end
			if (wr_en && awaddr_r == `OFS_PIN_SECOND) begin
				pin_second_r <= wdata_r;
			end
		end
	end

	// outputs toward the pins, analog front end and interrupt controller
	always_ff @(posedge aclk) begin
		if (mod_rst) begin
			irq_r <= 1'b0;
			frontend_r <= '0;
		end else begin
			irq_r <= sc1_r.completion_flag && sc1_r.completion_interrupt_enable;
			frontend_r.sampling <= state_nxt == st_sample;
			frontend_r.converting <= state_nxt == st_convert;
			frontend_r.channel_select <= sc1_r.channel_select;
		end
	end

	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign frontend = frontend_r;
	assign analog_pin_disable = {pin_second_r, pin_first_r};
	assign converter_irq = irq_r;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (mod_rst);

	chk_wait_no_abort: assert property (
		(wait_mode && state_r == st_convert && !abort && !complete) |=> state_r == st_convert)
		else $error("conversion lost in wait mode");
	chk_trigger_start: assert property (
		(edge_in[0] && sc2_r.trigger_select && sc1_r.channel_select != `CHANNEL_OFF &&
		!abort && state_r == st_idle) |=> (state_r == st_sample && cnt_r == $past(sample_len)))
		else $error("hardware trigger did not start sampling");
	chk_stop_abort: assert property (
		stop_abort |=> state_r == st_idle ##1 (state_r == st_idle || $past(start)))
		else $error("stop without async clock left converter running");
	chk_result_hold: assert property (
		$changed(result_r) |-> $past(transfer || mod_rst))
		else $error("result changed without transfer");
	chk_async_stop3: assert property (
		(stop3_mode && cfg_r.input_clock_source == `SRC_ASYNC && state_r != st_idle &&
		!abort && !complete) |=> state_r != st_idle)
		else $error("async conversion stopped in stop3");
	chk_flag_irq: assert property (
		(sc1_r.completion_flag && sc1_r.completion_interrupt_enable) |=> converter_irq)
		else $error("interrupt missing with flag and enable set");
	chk_block_drop: assert property (
		(complete_ok && block_r && !sc1_r.completion_flag) |=> !sc1_r.completion_flag)
		else $error("blocked result set completion flag");
	chk_sample_phase: assert property (
		(state_r == st_sample && adck_tick && cnt_r == 6'h00 && !abort && !start)
		|=> (state_r == st_convert && cnt_r == $past(conv_len)))
		else $error("sample phase did not hand over to conversion");
	chk_sc1_write: assert property (
		(sc1_wr && wdata_r[4:0] == `CHANNEL_OFF) |=> state_r == st_idle)
		else $error("write with channel off did not stop converter");
	chk_sc2_zero: assert property (
		(rd_fire && s_axi_araddr == `OFS_SC2) |=> (s_axi_rdata[3:0] == 4'h0))
		else $error("control two low bits not zero");
	chk_flag_set: assert property (
		transfer |=> sc1_r.completion_flag ##1 (converter_irq ||
		!$past(sc1_r.completion_interrupt_enable) || !$past(sc1_r.completion_flag)))
		else $error("completion did not raise flag");

	cov_transfer: cover property (transfer ##[1:4] converter_irq);
	cov_continuous: cover property (complete_ok && sc1_r.continuous_select ##1 state_r == st_sample);
	cov_blocked: cover property (complete_ok && block_r);
	cov_stop3_async: cover property (stop3_mode && transfer);

endmodule
`default_nettype wire

//--- verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	import adc_pkg::*;
	typedef struct {
		logic [7:0] a;
		logic wr;
		logic [7:0] d;
		logic [7:0] e;
		logic [1:0] r;
	} row_type;
	logic aclk, aresetn;
	logic [7:0] awaddr, araddr;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	logic wait_mode, stop3_mode, stop2_mode, hw_trig;
	logic [11:0] conv_data;
	frontend_type frontend;
	logic [15:0] pin_dis;
	logic irq;
	int failures, tests_run;
	row_type rows[11];

	adc_lowpower_mode_control #(.ASYNC_DIV(4)) dut (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(awaddr),
		.s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid),
		.s_axi_awready(awready),
		.s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid),
		.s_axi_wready(wready),
		.s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid),
		.s_axi_bready(bready),
		.s_axi_araddr(araddr),
		.s_axi_arprot(3'h0),
		.s_axi_arvalid(arvalid),
		.s_axi_arready(arready),
		.s_axi_rdata(rdata),
		.s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid),
		.s_axi_rready(rready),
		.wait_mode(wait_mode),
		.stop3_mode(stop3_mode),
		.stop2_mode(stop2_mode),
		.hardware_trigger_input(hw_trig),
		.alternate_clock_input(1'b0),
		.conversion_data(conv_data),
		.frontend(frontend),
		.analog_pin_disable(pin_dis),
		.converter_irq(irq)
	);

	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	task automatic wrap_up();
		if (failures == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t value %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t response %h expected %h", $time, got, exp);
		end
	endtask

	// each bus task starts one edge after the previous one ended
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!(bvalid && bready) && n < 100);
		bready <= 1'b0;
		if (n >= 100) begin
			failures++;
			$display("[FAIL] %0t write response timeout", $time);
		end
		chk_resp(bresp, er);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (arready) arvalid <= 1'b0;
		end while (!(rvalid && rready) && n < 100);
		rready <= 1'b0;
		if (n >= 100) begin
			failures++;
			$display("[FAIL] %0t read response timeout", $time);
		end
		chk_val(rdata[15:0], {8'h00, ed});
		chk_resp(rresp, er);
	endtask

	// skips one edge so a stale level is not taken, then waits up to 200 cycles
	task automatic wait_irq(input logic exp);
		int n;
		n = 0;
		@(posedge aclk);
		while (irq !== 1'b1 && n < 200) begin
			@(posedge aclk);
			n++;
		end
		chk_val({15'h0, irq}, {15'h0, exp});
	endtask

	initial begin
		#2000000;
		failures++;
		$display("[FAIL] %0t watchdog expired", $time);
		wrap_up();
	end

	initial begin
		aresetn = 1'b0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wait_mode = 1'b0;
		stop3_mode = 1'b0;
		stop2_mode = 1'b0;
		hw_trig = 1'b0;
		conv_data = 12'hABC;
		rows = '{
			'{8'h00, 1'b0, 8'h00, 8'h1F, 2'h0},
			'{8'h04, 1'b0, 8'h00, 8'h00, 2'h0},
			'{8'h18, 1'b0, 8'h00, 8'h00, 2'h0},
			'{8'h08, 1'b0, 8'h00, 8'h00, 2'h0},
			'{8'h18, 1'b1, 8'h98, 8'h98, 2'h0},
			'{8'h04, 1'b1, 8'h7C, 8'h70, 2'h0},
			'{8'h04, 1'b1, 8'h00, 8'h00, 2'h0},
			'{8'h10, 1'b1, 8'hFF, 8'h0F, 2'h0},
			'{8'h14, 1'b1, 8'hA5, 8'hA5, 2'h0},
			'{8'h1C, 1'b1, 8'h02, 8'h02, 2'h0},
			'{8'h40, 1'b1, 8'h55, 8'h00, 2'h2}
		};
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (rows[i]) begin
			if (rows[i].wr) wr(rows[i].a, rows[i].d, rows[i].r);
			rd(rows[i].a, rows[i].e, rows[i].r);
		end
		chk_val(pin_dis, 16'h0002);
		// single 12-bit conversion on channel 1 in wait mode
		wr(8'h18, 8'h04, 2'h0);
		wait_mode <= 1'b1;
		wr(8'h00, 8'h41, 2'h0);
		repeat (8) @(posedge aclk);
		chk_val({9'h0, frontend}, {9'h0, 2'b01, 5'h01});
		rd(8'h04, 8'h80, 2'h0);
		wait_irq(1'b1);
		rd(8'h00, 8'hC1, 2'h0);
		rd(8'h08, 8'h0A, 2'h0);
		rd(8'h0C, 8'hBC, 2'h0);
		rd(8'h00, 8'h41, 2'h0);
		repeat (2) @(posedge aclk);
		chk_val({15'h0, irq}, 16'h0000);
		// continuous: a pending high read keeps the old pair
		wr(8'h00, 8'h61, 2'h0);
		wait_irq(1'b1);
		rd(8'h08, 8'h0A, 2'h0);
		conv_data <= 12'h123;
		repeat (60) @(posedge aclk);
		rd(8'h0C, 8'hBC, 2'h0);
		wait_irq(1'b1);
		rd(8'h08, 8'h01, 2'h0);
		rd(8'h0C, 8'h23, 2'h0);
		wr(8'h00, 8'h1F, 2'h0);
		// stop3 on bus clock aborts and keeps results
		conv_data <= 12'h456;
		wr(8'h00, 8'h01, 2'h0);
		stop3_mode <= 1'b1;
		repeat (40) @(posedge aclk);
		stop3_mode <= 1'b0;
		repeat (40) @(posedge aclk);
		rd(8'h00, 8'h01, 2'h0);
		rd(8'h04, 8'h00, 2'h0);
		rd(8'h08, 8'h01, 2'h0);
		rd(8'h0C, 8'h23, 2'h0);
		wr(8'h00, 8'h01, 2'h0);
		repeat (40) @(posedge aclk);
		chk_val({15'h0, irq}, 16'h0000);
		rd(8'h00, 8'h81, 2'h0);
		rd(8'h08, 8'h04, 2'h0);
		rd(8'h0C, 8'h56, 2'h0);
		// stop3 on the asynchronous clock keeps converting
		wr(8'h18, 8'h07, 2'h0);
		conv_data <= 12'h789;
		wr(8'h00, 8'h41, 2'h0);
		stop3_mode <= 1'b1;
		wait_irq(1'b1);
		rd(8'h08, 8'h07, 2'h0);
		rd(8'h0C, 8'h89, 2'h0);
		stop3_mode <= 1'b0;
		// hardware trigger in wait mode
		wr(8'h18, 8'h05, 2'h0);
		wr(8'h04, 8'h40, 2'h0);
		wr(8'h00, 8'h41, 2'h0);
		repeat (30) @(posedge aclk);
		chk_val({15'h0, irq}, 16'h0000);
		hw_trig <= 1'b1;
		conv_data <= 12'h3C5;
		wait_irq(1'b1);
		hw_trig <= 1'b0;
		rd(8'h08, 8'h03, 2'h0);
		rd(8'h0C, 8'hC5, 2'h0);
		wr(8'h04, 8'h00, 2'h0);
		// long sample, then aborted by a control-one write
		wr(8'h18, 8'h14, 2'h0);
		wr(8'h00, 8'h41, 2'h0);
		repeat (8) @(posedge aclk);
		chk_val({15'h0, frontend.sampling}, 16'h0001);
		wr(8'h00, 8'h1F, 2'h0);
		wait_irq(1'b0);
		rd(8'h00, 8'h1F, 2'h0);
		// compare against 0xFA5: greater fails, less stores the difference
		wr(8'h18, 8'h04, 2'h0);
		wr(8'h04, 8'h30, 2'h0);
		wr(8'h00, 8'h01, 2'h0);
		repeat (40) @(posedge aclk);
		rd(8'h00, 8'h01, 2'h0);
		wr(8'h04, 8'h20, 2'h0);
		wr(8'h00, 8'h01, 2'h0);
		repeat (40) @(posedge aclk);
		rd(8'h00, 8'h81, 2'h0);
		rd(8'h08, 8'h04, 2'h0);
		rd(8'h0C, 8'h20, 2'h0);
		// stop2 returns registers to reset
		wr(8'h18, 8'h98, 2'h0);
		wr(8'h1C, 8'h02, 2'h0);
		stop2_mode <= 1'b1;
		repeat (2) @(posedge aclk);
		stop2_mode <= 1'b0;
		rd(8'h18, 8'h00, 2'h0);
		rd(8'h00, 8'h1F, 2'h0);
		chk_val(pin_dis, 16'h0000);
		// reprogram in order after stop2: 8-bit single conversion
		wr(8'h18, 8'h00, 2'h0);
		wr(8'h04, 8'h00, 2'h0);
		wr(8'h00, 8'h41, 2'h0);
		wait_irq(1'b1);
		rd(8'h08, 8'h00, 2'h0);
		rd(8'h0C, 8'h3C, 2'h0);
		wrap_up();
	end
endmodule

`default_nettype wire
